// >>> hw/lcc_charger.sv
// Charge controller: enable gating, charge sequencing, faults, timers, watchdog
//
// Behaviour
// - Charging allowed only with enable pin low and inhibit bit zero.
// - Enable pin high with valid input keeps charge transistor off.
// - Input valid only above undervoltage, above battery+sleep, below overvoltage.
// - Below pre-charge exit voltage: pre-charge current, timer limit 25 percent.
// - At pre-charge exit voltage switch to fast charge current.
// - Terminate at termination current only while CV loop active in fast charge.
// - No termination while input, power-path or thermal loop active.
// - No termination while battery temperature is warm.
// - Any charge current change pauses charging about 1 ms first.
// - Input-voltage loop off after reset, host enables; threshold 4.2-4.9 V.
// - Power-path loop reduces charge current when rail drops near battery.
// - Power-path loop inactive when rail tracks battery.
// - Active input or power-path loop sets status bits and flags.
// - Supplement mode enter/exit by offsets; termination disabled throughout.
// - Overvoltage: input transistor off, one interrupt pulse, flag and status set.
// - Overvoltage status clears with fault; flag clears on read after fault gone.
// - Safety timer starts each cycle; expiry without termination disables charge.
// - Safety timer expiry: one interrupt pulse and fault flag set.
// - Timer fault left only by toggling enable pin or input power.
// - Timer fault flag clears on host read even if fault persists.
// - New timer duration written while running restarts the timer.
// - Doubling option: timer half rate while non-CC/CV loop active.
// - 50 s watchdog restarts on bus transaction; expiry restores defaults.
// - Each interrupt is one active-low 128 us pulse.
`timescale 1ns/1ns
`default_nettype none
module lcc_charger
    import lcc_pkg::*;
#(
    parameter int MS_TICK = MS_CYC,          // Cycles per millisecond tick
    parameter int PAUSE_LEN = PAUSE_CYC,     // Current-change pause cycles
    parameter int WDOG_LEN = WDOG_MS,        // Watchdog length in ticks
    parameter int MIN_LEN = MIN_MS           // Ticks per safety minute
) (
    input wire logic clk,                    // System clock, 50 MHz
    input wire logic rst,                    // Synchronous reset, active high
    input wire logic charge_enable_n,        // Charge-enable pin, active low
    input wire lcc_ana_t ana_in,             // Raw analog loop/comparator states
    input wire logic cfg_wr,                 // Host parameter write strobe
    input wire lcc_cfg_t cfg_wdata,          // Host parameter write data
    input wire logic bus_txn,                // Pulse on every bus transaction
    input wire logic wdog_en,                // Watchdog enable, high from reset
    input wire logic flag_rd,                // Host read of the flag register
    output lcc_cfg_t cfg,                    // Current charger parameters
    output lcc_stat_t stat,                  // Live status bits
    output logic [3:0] flags,                // {timer, ovp, path, vin} flags
    output logic charge_fet_on,              // Battery charge transistor on
    output logic input_fet_on,               // Input transistor on
    output logic [7:0] current_code,         // Applied charge current code
    output logic int_n                       // Interrupt output, active low
);
    ////////////////////////////////////////////////////////////////////////
    lcc_ana_t a;
    lcc_sync #(.W($bits(lcc_ana_t))) u_sync (.clk(clk), .rst(rst), .d(ana_in), .q(a));
    logic ce_n_s;
    lcc_sync #(.W(1)) u_ce_sync (.clk(clk), .rst(rst), .d(charge_enable_n), .q(ce_n_s));

    lcc_state_t state_reg;
    logic input_valid, enable, power_loop, supp_reg, ce_n_d_reg, valid_d_reg, toggle;
    logic [31:0] ms_cnt_reg, pause_cnt_reg, wd_cnt_reg, tmr_ms_reg, int_cnt_reg;
    logic [9:0] tmr_min_reg, limit_min;
    logic half_reg, expire, terminate, ovp_d_reg;
    logic [7:0] target_code;
    logic [3:0] flags_reg;
    logic ms_tick, wd_expire;

    function automatic logic [9:0] safety_minutes(input logic [1:0] sel);
        case (sel)
            2'h0: safety_minutes = TMR_MIN_0;
            2'h1: safety_minutes = TMR_MIN_1;
            default: safety_minutes = TMR_MIN_2;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Input validity and enable gating
    assign input_valid = a.vin_above_uvlo && a.vin_above_sleep && !a.vin_overvoltage;
    assign enable = !ce_n_s && !cfg.charge_disable;
    // Loops other than CC/CV, plus warm battery temperature; path loop ignored while tracking battery
    assign power_loop = (a.vin_loop && cfg.vin_loop_en) || (a.path_loop && !cfg.track_mode)
                        || a.thermal_loop || a.temp_warm;
    assign terminate = state_reg == ST_FAST && a.at_termination_current && a.cv_loop
                       && !(a.vin_loop && cfg.vin_loop_en) && !(a.path_loop && !cfg.track_mode)
                       && !a.thermal_loop
                       && !a.temp_warm
                       && !supp_reg;
    assign toggle = (ce_n_s && !ce_n_d_reg) || (!input_valid && valid_d_reg);

    // Millisecond tick divider
    assign ms_tick = ms_cnt_reg == 32'(MS_TICK - 1);
    always_ff @(posedge clk) begin
        if (rst || ms_tick) ms_cnt_reg <= '0;
        else ms_cnt_reg <= ms_cnt_reg + 32'h1;
    end

    // Edge history for toggle detection and the overvoltage interrupt edge
    always_ff @(posedge clk) begin
        if (rst) begin
            ce_n_d_reg <= 1'b0;
            valid_d_reg <= 1'b0;
            ovp_d_reg <= 1'b0;
        end else begin
            ce_n_d_reg <= ce_n_s;
            valid_d_reg <= input_valid;
            ovp_d_reg <= a.vin_overvoltage;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog: restarts on each transaction, restores defaults on expiry
    assign wd_expire = wdog_en && ms_tick && wd_cnt_reg == 32'(WDOG_LEN - 1);
    always_ff @(posedge clk) begin
        if (rst || bus_txn || !wdog_en || wd_expire) wd_cnt_reg <= '0;
        else if (ms_tick) wd_cnt_reg <= wd_cnt_reg + 32'h1;
    end

    // Parameter registers
    always_ff @(posedge clk) begin
        if (rst || wd_expire) cfg <= CFG_RST;
        else if (cfg_wr) cfg <= cfg_wdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Charge state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: if (input_valid && enable)
                    state_reg <= a.below_precharge_exit ? ST_PRE : ST_FAST;
                ST_PRE: begin
                    if (!input_valid || !enable) state_reg <= ST_IDLE;
                    else if (expire) state_reg <= ST_FAULT;
                    else if (!a.below_precharge_exit) state_reg <= ST_FAST;
                end
                ST_FAST: begin
                    if (!input_valid || !enable) state_reg <= ST_IDLE;
                    else if (expire) state_reg <= ST_FAULT;
                    else if (terminate) state_reg <= ST_DONE;
                end
                ST_DONE: if (!input_valid || !enable) state_reg <= ST_IDLE;
                ST_FAULT: if (toggle) state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Supplement mode hysteresis
    always_ff @(posedge clk) begin
        if (rst) supp_reg <= 1'b0;
        else if (a.rail_below_entry) supp_reg <= 1'b1;
        else if (a.rail_above_exit) supp_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Safety timer; pre-charge limit is a quarter of fast limit
    assign limit_min = (state_reg == ST_PRE) ? safety_minutes(cfg.safety_sel) / 10'(PRE_DIV)
                                             : safety_minutes(cfg.safety_sel);
    assign expire = tmr_min_reg >= limit_min;
    always_ff @(posedge clk) begin
        if (rst || state_reg == ST_IDLE || state_reg == ST_DONE
            || (cfg_wr && cfg_wdata.safety_sel != cfg.safety_sel)) begin
            tmr_ms_reg <= '0;
            tmr_min_reg <= '0;
            half_reg <= 1'b0;
        end else if (state_reg != ST_FAULT && ms_tick) begin
            half_reg <= !half_reg;
            if (!(cfg.timer_doubling_enable && power_loop && half_reg)) begin
                if (tmr_ms_reg == 32'(MIN_LEN - 1)) begin
                    tmr_ms_reg <= '0;
                    tmr_min_reg <= tmr_min_reg + 10'h1;
                end else begin
                    tmr_ms_reg <= tmr_ms_reg + 32'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Current setting with pause on every change
    assign target_code = (state_reg == ST_PRE) ? cfg.pre_code : cfg.fast_code;
    always_ff @(posedge clk) begin
        if (rst) begin
            current_code <= CFG_RST.pre_code;
            pause_cnt_reg <= '0;
        end else if (pause_cnt_reg != 0) begin
            pause_cnt_reg <= pause_cnt_reg - 32'h1;
            if (pause_cnt_reg == 32'h1) current_code <= target_code;
        end else if (target_code != current_code) begin
            pause_cnt_reg <= 32'(PAUSE_LEN);
        end
    end

    // Transistor drive
    always_ff @(posedge clk) begin
        if (rst) begin
            charge_fet_on <= 1'b0;
            input_fet_on <= 1'b0;
        end else begin
            charge_fet_on <= (state_reg == ST_PRE || state_reg == ST_FAST) && enable
                             && input_valid && pause_cnt_reg == 0;
            input_fet_on <= !a.vin_overvoltage;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags: set wins over read-clear
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_reg <= '0;
        end else begin
            flags_reg[0] <= (a.vin_loop && cfg.vin_loop_en) || (flags_reg[0] && !flag_rd);
            flags_reg[1] <= (a.path_loop && !cfg.track_mode)
                            || (flags_reg[1] && !flag_rd);
            flags_reg[2] <= a.vin_overvoltage
                            || (flags_reg[2] && !flag_rd);
            flags_reg[3] <= (expire && (state_reg == ST_PRE || state_reg == ST_FAST))
                            || (flags_reg[3] && !flag_rd);
        end
    end
    assign flags = flags_reg;

    // Live status
    always_ff @(posedge clk) begin
        if (rst) begin
            stat <= '0;
        end else begin
            stat.vin_loop_stat <= a.vin_loop && cfg.vin_loop_en;
            stat.path_loop_stat <= a.path_loop && !cfg.track_mode;
            stat.ovp_stat <= a.vin_overvoltage;
            stat.supplement <= supp_reg;
            stat.charging <= state_reg == ST_PRE || state_reg == ST_FAST;
            stat.fast <= state_reg == ST_FAST;
            stat.done <= state_reg == ST_DONE;
            stat.timer_fault <= state_reg == ST_FAULT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt pulse generator, 128 us low per event
    always_ff @(posedge clk) begin
        if (rst) int_cnt_reg <= '0;
        else if ((a.vin_overvoltage && !ovp_d_reg)
                 || (expire && (state_reg == ST_PRE || state_reg == ST_FAST)))
            int_cnt_reg <= 32'(INT_PULSE_CYC);
        else if (int_cnt_reg != 0) int_cnt_reg <= int_cnt_reg - 32'h1;
    end
    assign int_n = (int_cnt_reg == 0);

    ////////////////////////////////////////////////////////////////////////
    a_int_width: assert property (@(posedge clk) disable iff (rst)
        $fell(int_n) |-> !int_n [*8]) else $error("Interrupt pulse too short");
    a_fet_gate: assert property (@(posedge clk) disable iff (rst)
        charge_fet_on |-> !$past(cfg.charge_disable) && $past(input_valid)) else $error("Charge while disabled");
    a_ovp_input: assert property (@(posedge clk) disable iff (rst)
        a.vin_overvoltage |=> !input_fet_on) else $error("Input transistor on in overvoltage");
    a_ovp_flag: assert property (@(posedge clk) disable iff (rst)
        a.vin_overvoltage |=> flags[2] && stat.ovp_stat) else $error("Overvoltage flag not set");
    a_fault_stay: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_FAULT && !toggle |=> state_reg == ST_FAULT) else $error("Fault left without toggle");
    a_term_qual: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_FAST && a.temp_warm |=> state_reg != ST_DONE) else $error("Terminated while warm");
    a_pause_off: assert property (@(posedge clk) disable iff (rst)
        pause_cnt_reg != 0 |=> !charge_fet_on) else $error("Charging during pause");
    a_tmr_flag: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_FAST && expire |=> flags[3] && !int_n) else $error("Timer expiry not flagged");
    a_wd_default: assert property (@(posedge clk) disable iff (rst)
        wd_expire |=> cfg == CFG_RST) else $error("Watchdog did not restore defaults");
endmodule // lcc_charger
`default_nettype wire

// >>> hw/lcc_pkg.sv
// Package: shared constants and carrier types for the linear charge controller
package lcc_pkg;
    // Clock rate and derived counts
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_NS = 20;
    localparam int INT_PULSE_NS = 128_000;                         // Interrupt pulse width, ns
    localparam int INT_PULSE_CYC = INT_PULSE_NS / CLK_NS;          // Rounds down, longest time
    localparam int PAUSE_US = 1000;                                // Current-change pause, us
    localparam int PAUSE_CYC = PAUSE_US * 1000 / CLK_NS;           // Pause in cycles
    localparam int MS_CYC = CLK_HZ / 1000;                         // One millisecond tick
    localparam int WDOG_S = 50;                                    // Host watchdog, s
    localparam int WDOG_MS = WDOG_S * 1000;                        // Watchdog in ms ticks
    localparam int MIN_MS = 60_000;                                // Milliseconds per minute
    localparam int PRE_DIV = 4;                                    // Pre-charge limit is 25%
    // Safety timer settings, minutes
    localparam logic [9:0] TMR_MIN_0 = 10'h0b4;                    // 180 min
    localparam logic [9:0] TMR_MIN_1 = 10'h168;                    // 360 min
    localparam logic [9:0] TMR_MIN_2 = 10'h2d0;                    // 720 min
    localparam logic [1:0] SAFETY_SEL_RST = 2'h0;
    // Input-voltage loop threshold code: 4.2 V + code*100 mV, 0..7
    localparam logic [2:0] VIN_THR_RST = 3'h0;
    localparam logic [2:0] VIN_THR_MAX = 3'h7;
    // Charger parameter block, defaults restored by the watchdog
    typedef struct packed {
        logic       charge_disable;    // Charge-inhibit bit
        logic       vin_loop_en;       // Input-voltage loop enable
        logic [2:0] vin_thr;           // Input-voltage loop threshold code
        logic [1:0] safety_sel;        // Safety timer duration select
        logic       timer_doubling_enable;
        logic       track_mode;        // System rail tracks battery
        logic [7:0] fast_code;         // Fast-charge current code
        logic [7:0] pre_code;          // Pre-charge current code
    } lcc_cfg_t;
    localparam lcc_cfg_t CFG_RST = '{1'b0, 1'b0, VIN_THR_RST, SAFETY_SEL_RST, 1'b0, 1'b0,
                                     8'h40, 8'h08};
    // Synchronized analog status inputs
    typedef struct packed {
        logic vin_above_uvlo;
        logic vin_above_sleep;
        logic vin_overvoltage;
        logic below_precharge_exit;
        logic at_termination_current;
        logic cv_loop;
        logic cc_loop;
        logic vin_loop;
        logic path_loop;
        logic thermal_loop;
        logic temp_warm;
        logic rail_below_entry;
        logic rail_above_exit;
    } lcc_ana_t;
    // Reported status
    typedef struct packed {
        logic vin_loop_stat;
        logic path_loop_stat;
        logic ovp_stat;
        logic supplement;
        logic charging;
        logic fast;
        logic done;
        logic timer_fault;
    } lcc_stat_t;
    typedef enum {ST_IDLE, ST_PRE, ST_FAST, ST_DONE, ST_FAULT} lcc_state_t;
endpackage

// >>> hw/lcc_sync.sv
// Two flip-flop synchronizer for a bundle of levels
`timescale 1ns/1ns
`default_nettype none
module lcc_sync #(
    parameter int W = 1
) (
    input wire logic clk,            // System clock
    input wire logic rst,            // Synchronous reset
    input wire logic [W-1:0] d,      // Asynchronous levels
    output logic [W-1:0] q           // Synchronized levels
);
    logic [W-1:0] meta_reg;

    // Two stages; the first feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // lcc_sync
`default_nettype wire

// >>> verification/lcc_host_model.sv
// Host-side model: parameter writes, flag reads and bus keep-alive pulses
`timescale 1ns/1ns
`default_nettype none
module lcc_host_model
    import lcc_pkg::*;
(
    input wire logic clk,         // System clock
    input wire logic keep,        // Send periodic keep-alive transactions
    output logic cfg_wr,          // Parameter write strobe
    output lcc_cfg_t cfg_wdata,   // Parameter write data
    output logic flag_rd,         // Flag register read strobe
    output logic bus_txn          // One pulse per bus transaction
);
    logic txn_acc;
    logic txn_keep;
    int gap;
    // Idle levels from time zero
    initial begin
        cfg_wr = 1'b0;
        cfg_wdata = '0;
        flag_rd = 1'b0;
        txn_acc = 1'b0;
    end
    // Every access is also a bus transaction
    assign bus_txn = txn_acc | txn_keep;
    ////////////////////////////////////////////////////////////////////////////////
    // One-cycle write; data scrambled once released so stale values are never seen
    task automatic write(input lcc_cfg_t d);
        @(negedge clk);
        cfg_wdata = d;
        cfg_wr = 1'b1;
        txn_acc = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
        txn_acc = 1'b0;
        cfg_wdata = ~d;
    endtask
    // One-cycle read of the flag register
    task automatic read();
        @(negedge clk);
        flag_rd = 1'b1;
        txn_acc = 1'b1;
        @(negedge clk);
        flag_rd = 1'b0;
        txn_acc = 1'b0;
    endtask
    // Keep-alive traffic so the watchdog fires only when the bench wants it
    always @(negedge clk) begin
        gap <= (gap >= 63) ? 0 : gap + 1;
        txn_keep <= keep && (gap == 0);
    end
endmodule // lcc_host_model
`default_nettype wire

// >>> verification/lcc_charger_test.sv
// Self-checking testbench of the charge controller
`timescale 1ns/1ns
`default_nettype none
module lcc_charger_test
    import lcc_pkg::*;
();
    localparam int MT = 10;
    localparam int PL = 20;
    localparam int WL = 20;
    localparam int ML = 2;
    localparam int PRE_LIM = TMR_MIN_0 * ML * MT / PRE_DIV; // Pre-charge limit in cycles
    logic clk;
    logic rst;
    logic en_n;
    logic keep;
    lcc_ana_t ana;
    logic cfg_wr;
    lcc_cfg_t cfg_wdata;
    logic flag_rd;
    logic bus_txn;
    lcc_cfg_t cfg;
    lcc_stat_t stat;
    logic [3:0] flags;
    logic chg_on;
    logic in_on;
    logic [7:0] code;
    logic int_n;
    lcc_cfg_t wcfg;
    int failures;
    int check_count;
    int n;
    int k;
    integer seed;
    // Design with shortened counts
    lcc_charger #(.MS_TICK(MT), .PAUSE_LEN(PL), .WDOG_LEN(WL), .MIN_LEN(ML)) dut (.clk(clk), .rst(rst),
        .charge_enable_n(en_n), .ana_in(ana), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .bus_txn(bus_txn),
        .wdog_en(1'b1), .flag_rd(flag_rd), .cfg(cfg), .stat(stat), .flags(flags), .charge_fet_on(chg_on),
        .input_fet_on(in_on), .current_code(code), .int_n(int_n));
    // Host on the far side
    lcc_host_model host (.clk(clk), .keep(keep), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .flag_rd(flag_rd),
        .bus_txn(bus_txn));
    // Clock, 20 ns period
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Reference model of the enable gating
    function automatic logic exp_on(input int pin, input int inhibit, input int valid);
        return (pin == 0 && inhibit == 0 && valid == 1);
    endfunction
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // A wait that ran out ends the run
    task automatic need(input logic ok);
        check(ok, 1'b1);
        if (ok !== 1'b1) final_report();
    endtask
    task automatic step(input int c);
        repeat (c) @(negedge clk);
    endtask
    task automatic test_done(input string s);
        $display("Test %s finished, mismatches so far %0d", s, failures);
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence, inputs driven at the falling edge
    initial begin
        failures = 0;
        check_count = 0;
        seed = 32'h2fe04c10;
        rst = 1'b1;
        en_n = 1'b1;
        keep = 1'b1;
        ana = '0;
        ana.vin_above_uvlo = 1'b1;
        ana.vin_above_sleep = 1'b1;
        step(8);
        rst = 1'b0;
        step(1);
        check(cfg, CFG_RST);
        check({stat, flags, int_n, chg_on}, {8'h00, 4'h0, 1'b1, 1'b0});
        test_done("reset");
        // Pin/bit table, plus one case with input below undervoltage
        for (k = 0; k < 5; k++) begin
            ana.vin_above_uvlo = (k != 4);
            wcfg = CFG_RST;
            wcfg.charge_disable = k[0];
            wcfg.fast_code = 8'($random(seed));
            host.write(wcfg);
            en_n = k[1];
            for (n = 0; n < 100 && chg_on !== 1'b1; n++) step(1);
            check(chg_on, exp_on(k % 4 / 2, k % 2, k != 4 ? 1 : 0));
            if (k == 0) begin
                check({stat.fast, code}, {1'b1, wcfg.fast_code});
                wcfg.fast_code = ~wcfg.fast_code;
                host.write(wcfg);
                for (n = 0; n < 10 && chg_on !== 1'b0; n++) step(1);
                check({chg_on, code}, {1'b0, ~wcfg.fast_code});
                for (n = 0; n < PL + 40 && chg_on !== 1'b1; n++) step(1);
                check({chg_on, code}, {1'b1, wcfg.fast_code});
            end
            en_n = 1'b1;
            step(10);
        end
        ana.vin_above_uvlo = 1'b1;
        test_done("enable");
        // Termination blocked by warm, loops and supplement mode; the input loop counts only once enabled
        wcfg.vin_loop_en = 1'b1;
        host.write(wcfg);
        en_n = 1'b0;
        for (n = 0; n < 100 && chg_on !== 1'b1; n++) step(1);
        need(chg_on === 1'b1);
        ana.cv_loop = 1'b1;
        ana.at_termination_current = 1'b1;
        for (k = 0; k < 5; k++) begin
            ana.temp_warm = (k == 0);
            ana.vin_loop = (k == 1);
            ana.path_loop = (k == 2);
            ana.thermal_loop = (k == 3);
            ana.rail_below_entry = (k >= 3); // Overlaps the thermal step: supplement state lags one cycle
            step(40);
            check(stat.done, 1'b0);
        end
        check({flags[1:0], stat.supplement}, 3'h7);
        ana.rail_below_entry = 1'b0;
        ana.rail_above_exit = 1'b1;
        for (n = 0; n < 40 && stat.done !== 1'b1; n++) step(1);
        check(stat.done, 1'b1);
        host.read();
        step(1);
        check(flags, 4'h0);
        test_done("termination");
        // Overvoltage pulse, flag and status
        ana.vin_overvoltage = 1'b1;
        for (n = 0; n < 10 && int_n !== 1'b0; n++) step(1);
        need(int_n === 1'b0);
        check({in_on, flags[2], stat.ovp_stat}, 3'h3);
        for (n = 0; n < 7000 && int_n === 1'b0; n++) step(1);
        check(n, INT_PULSE_CYC);
        ana.vin_overvoltage = 1'b0;
        step(6);
        check({stat.ovp_stat, flags[2], in_on}, 3'h3);
        host.read();
        step(1);
        check(flags[2], 1'b0);
        test_done("overvoltage");
        // Pre-charge safety timer expiry and recovery
        en_n = 1'b1;
        ana.below_precharge_exit = 1'b1;
        step(10);
        en_n = 1'b0;
        for (n = 0; n < 2000 && stat.timer_fault !== 1'b1; n++) step(1);
        need(stat.timer_fault === 1'b1);
        check(n > PRE_LIM - 40 && n < PRE_LIM + PL + 60, 1'b1);
        check({chg_on, flags[3], int_n}, 3'h2);
        host.read();
        step(1);
        check({stat.timer_fault, flags[3]}, 2'h2);
        en_n = 1'b1;
        step(10);
        en_n = 1'b0;
        step(10);
        check(stat.timer_fault, 1'b0);
        en_n = 1'b1;
        test_done("safety timer");
        // Power-path loop ignored while the rail tracks the battery
        wcfg = CFG_RST;
        wcfg.track_mode = 1'b1;
        host.write(wcfg);
        ana.path_loop = 1'b1;
        step(6);
        check({flags[1], stat.path_loop_stat}, 2'h0);
        ana.path_loop = 1'b0;
        test_done("tracking");
        // Watchdog restores defaults without bus traffic
        wcfg = CFG_RST;
        wcfg.vin_loop_en = 1'b1;
        wcfg.vin_thr = VIN_THR_MAX;
        wcfg.safety_sel = 2'h2;
        keep = 1'b0;
        host.write(wcfg);
        check(cfg, wcfg);
        for (n = 0; n < 400 && cfg !== CFG_RST; n++) step(1);
        need(cfg === CFG_RST);
        check(n > WL * MT - 20, 1'b1);
        test_done("watchdog");
        final_report();
    end
endmodule // lcc_charger_test
`default_nettype wire
